//--- pkg/twm_pkg.sv
// Notes on behaviour
// - Writing 1 to bit 0 of the begin-receive trigger starts a bus read.
// - Writing 1 to bit 0 of the begin-transmit trigger starts a bus write.
// - Writing the end-transaction trigger ends the current transaction.
// - A byte landing in the receive data register sets its flag to 1.
// - The byte-boundary flag is raised before every byte sent or received.
// - In a read, the paused flag is raised right after the ack bit.
// - Pausing needs an earlier pause trigger; continue resumes the read.
// - The master has a paused state whose entry sets its own flag.
// - The byte-sent flag rises after a data byte (not the address byte) is shifted out and acked.
// - After a received byte, SCL is held low until software reads it.
package twm_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] TWM_OFS_BEGIN_RX = 12'h000;
  localparam logic [11:0] TWM_OFS_BEGIN_TX = 12'h008;
  localparam logic [11:0] TWM_OFS_END = 12'h014;
  localparam logic [11:0] TWM_OFS_PAUSE = 12'h01c;
  localparam logic [11:0] TWM_OFS_CONTINUE = 12'h020;
  localparam logic [11:0] TWM_OFS_RXD = 12'h518;
  localparam logic [11:0] TWM_OFS_TXD = 12'h51c;
  localparam logic [11:0] TWM_OFS_ADDR = 12'h588;
  localparam logic [11:0] TWM_OFS_IRQ_STAT = 12'h600;
  localparam logic [11:0] TWM_OFS_IRQ_CLR = 12'h604;
  localparam logic [11:0] TWM_OFS_IRQ_EN = 12'h608;

  // ------------------------------------------------------------------
  // Event flags: index, offset, reset value
  // ------------------------------------------------------------------
  localparam int TWM_NEV = 6;
  localparam int TWM_EV_HALT = 0;
  localparam int TWM_EV_RX = 1;
  localparam int TWM_EV_TX = 2;
  localparam int TWM_EV_FAULT = 3;
  localparam int TWM_EV_BB = 4;
  localparam int TWM_EV_PAUSE = 5;
  localparam logic [11:0] TWM_EV_OFS [TWM_NEV] = '{
    12'h104, 12'h108, 12'h11c, 12'h124, 12'h138, 12'h148};
  localparam logic [TWM_NEV-1:0] TWM_EV_RST = 6'h00;
  localparam int TWM_TRIG_BIT = 0;
  localparam logic [2:0] TWM_BYTE_MSB = 3'h7;

  // ------------------------------------------------------------------
  // Timing: a quarter of the SCL period, least time
  // ------------------------------------------------------------------
  localparam int TWM_CLK_NS = 10;
  localparam int TWM_QTR_NS = 2500;
  localparam int TWM_QTR_CYC = (TWM_QTR_NS + TWM_CLK_NS - 1) / TWM_CLK_NS;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TWM_CMD_START, TWM_CMD_STOP, TWM_CMD_WR, TWM_CMD_RD
  } twm_cmd_t;
  typedef enum logic [1:0] {
    TWM_PEND_NONE, TWM_PEND_STOP, TWM_PEND_SRX, TWM_PEND_STX
  } twm_pend_t;
  typedef enum logic [3:0] {
    TWM_ST_IDLE = 4'h0, TWM_ST_START = 4'h1, TWM_ST_SHIFT = 4'h3,
    TWM_ST_ACKIN = 4'h2, TWM_ST_TXWAIT = 4'h6, TWM_ST_RXHOLD = 4'h7,
    TWM_ST_ACKOUT = 4'h5, TWM_ST_SUSP = 4'h4, TWM_ST_STOP = 4'hc
  } twm_state_t;

endpackage

//--- pkg/twm_bit_if.sv
`timescale 1ns/1ns
// Bit level command channel between byte sequencer and bus engine
interface twm_bit_if;
  logic req;
  twm_pkg::twm_cmd_t cmd;
  logic wbit;
  logic done;
  logic rbit;
  modport ctrl (output req, output cmd, output wbit, input done,
    input rbit);
  modport eng (input req, input cmd, input wbit, output done,
    output rbit);
endinterface

//--- hdl/twm_bit_engine.sv
`timescale 1ns/1ns
module twm_bit_engine #(
  parameter int QTR_CYC = twm_pkg::TWM_QTR_CYC,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Bit command channel
  twm_bit_if.eng bi,
  // Open-drain pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic busy;
    twm_pkg::twm_cmd_t cmd;
    logic wbit;
    logic [1:0] ph;
    logic [CW-1:0] cnt;
    logic scl_lo;
    logic sda_lo;
    logic rbit;
    logic done;
  } twm_eng_st_t;

  twm_eng_st_t q;
  twm_eng_st_t n;

  // Phase counter must fit; two cycles let the pin sync see SCL fall
  if (QTR_CYC < 2 || QTR_CYC >= 2 ** CW)
  begin : g_chk
    $error("QTR_CYC out of range");
  end

  // Pin drive per command and quarter phase: {scl low, sda low}
  function automatic logic [1:0] drv(twm_pkg::twm_cmd_t c, logic [1:0] p,
    logic b);
    logic edge_lo;
    edge_lo = (p == 2'h0) || (p == 2'h3);
    unique case (c)
      twm_pkg::TWM_CMD_START: drv = {edge_lo, p[1]};
      twm_pkg::TWM_CMD_STOP: drv = {p == 2'h0, !p[1]};
      twm_pkg::TWM_CMD_WR: drv = {edge_lo, !b};
      twm_pkg::TWM_CMD_RD: drv = {edge_lo, 1'b0};
    endcase
  endfunction

  // Phases 1 and 2 leave SCL released; a slave holding it low stalls us
  always_comb
  begin
    n = q;
    n.scl_m = i_scl;
    n.scl_s = q.scl_m;
    n.sda_m = i_sda;
    n.sda_s = q.sda_m;
    n.done = 1'b0;
    if (!q.busy)
    begin
      if (bi.req)
      begin
        n.busy = 1'b1;
        n.cmd = bi.cmd;
        n.wbit = bi.wbit;
        n.ph = 2'h0;
        n.cnt = '0;
        {n.scl_lo, n.sda_lo} = drv(bi.cmd, 2'h0, bi.wbit);
      end
    end
    else if (!(q.ph[0] ^ q.ph[1]) || q.scl_s)
    begin
      if (q.cnt == CW'(QTR_CYC - 1))
      begin
        n.cnt = '0;
        // Sample data at the end of the SCL high time
        if (q.ph == 2'h2 && q.cmd == twm_pkg::TWM_CMD_RD)
          n.rbit = q.sda_s;
        if (q.ph == 2'h3)
        begin
          n.busy = 1'b0;
          n.done = 1'b1;
        end
        else
        begin
          n.ph = q.ph + 2'h1;
          {n.scl_lo, n.sda_lo} = drv(q.cmd, n.ph, q.wbit);
        end
      end
      else
        n.cnt = q.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      q <= '0;
    else
      q <= n;
  end

  assign bi.done = q.done;
  assign bi.rbit = q.rbit;
  assign o_scl_oe = q.scl_lo;
  assign o_sda_oe = q.sda_lo;

endmodule

//--- hdl/twm_top.sv
`timescale 1ns/1ns
module twm_top #(
  parameter int QTR_CYC = twm_pkg::TWM_QTR_CYC
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Two-wire bus pins, open drain
  input wire logic I_SCL,
  output logic O_SCL,
  output logic O_SCL_OE,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // Interrupt
  output logic O_IRQ
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    twm_pkg::twm_state_t st;
    logic is_rx;
    logic addr_ph;
    logic wt;
    logic nack;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [7:0] rxd;
    logic [7:0] txd;
    logic txd_full;
    logic [6:0] addr;
    twm_pkg::twm_pend_t pend;
    logic susp;
    logic [twm_pkg::TWM_NEV-1:0] ev;
    logic [twm_pkg::TWM_NEV-1:0] irq_st;
    logic [twm_pkg::TWM_NEV-1:0] irq_en;
    logic irq;
    logic [31:0] prdata;
  } twm_top_st_t;

  twm_top_st_t q;
  twm_top_st_t n;
  twm_bit_if bi ();

  // ------------------------------------------------------------------
  // Bus engine
  // ------------------------------------------------------------------
  twm_bit_engine #(
    .QTR_CYC(QTR_CYC)
  ) u_eng (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .bi(bi),
    .i_scl(I_SCL),
    .i_sda(I_SDA),
    .o_scl_oe(O_SCL_OE),
    .o_sda_oe(O_SDA_OE)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Addresses that answer without an error
  function automatic logic mapped(logic [11:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < twm_pkg::TWM_NEV; i++)
      if (a == twm_pkg::TWM_EV_OFS[i])
        hit = 1'b1;
    unique case (a)
      twm_pkg::TWM_OFS_BEGIN_RX, twm_pkg::TWM_OFS_BEGIN_TX,
      twm_pkg::TWM_OFS_END, twm_pkg::TWM_OFS_PAUSE,
      twm_pkg::TWM_OFS_CONTINUE, twm_pkg::TWM_OFS_RXD,
      twm_pkg::TWM_OFS_TXD, twm_pkg::TWM_OFS_ADDR,
      twm_pkg::TWM_OFS_IRQ_STAT, twm_pkg::TWM_OFS_IRQ_CLR,
      twm_pkg::TWM_OFS_IRQ_EN: hit = 1'b1;
      default: ;
    endcase
    return hit;
  endfunction

  // Consume a pending start: load address byte with direction bit
  function automatic twm_top_st_t do_start(twm_top_st_t s);
    s.is_rx = (s.pend == twm_pkg::TWM_PEND_SRX);
    s.sh = {s.addr, s.is_rx};
    s.addr_ph = 1'b1;
    s.pend = twm_pkg::TWM_PEND_NONE;
    s.st = twm_pkg::TWM_ST_START;
    return s;
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic acc;
    logic wr;
    logic rd;
    logic w1;
    logic rxd_read;
    logic [twm_pkg::TWM_NEV-1:0] ev_set;
    logic [31:0] rmux;
    acc = I_PSEL && I_PENABLE;
    wr = acc && I_PWRITE;
    rd = acc && !I_PWRITE;
    w1 = I_PWDATA[twm_pkg::TWM_TRIG_BIT];
    rxd_read = rd && (I_PADDR == twm_pkg::TWM_OFS_RXD);
    ev_set = '0;
    rmux = 32'h0000_0000;
    n = q;
    bi.req = 1'b0;
    bi.cmd = twm_pkg::TWM_CMD_RD;
    bi.wbit = 1'b1;

    // Byte sequencer; START, SHIFT, ACKIN, ACKOUT and STOP each issue one bit command and wait
    unique case (q.st)
      twm_pkg::TWM_ST_IDLE:
      begin
        if (q.pend == twm_pkg::TWM_PEND_SRX ||
            q.pend == twm_pkg::TWM_PEND_STX)
          n = do_start(q);
        else if (q.pend == twm_pkg::TWM_PEND_STOP)
        begin
          // Already stopped: answer at once
          n.pend = twm_pkg::TWM_PEND_NONE;
          ev_set[twm_pkg::TWM_EV_HALT] = 1'b1;
        end
      end
      twm_pkg::TWM_ST_START:
      begin
        bi.cmd = twm_pkg::TWM_CMD_START;
        if (!q.wt)
        begin
          bi.req = 1'b1;
          n.wt = 1'b1;
        end
        else if (bi.done)
        begin
          n.wt = 1'b0;
          n.bitn = twm_pkg::TWM_BYTE_MSB;
          n.st = twm_pkg::TWM_ST_SHIFT;
          ev_set[twm_pkg::TWM_EV_BB] = 1'b1;
        end
      end
      twm_pkg::TWM_ST_SHIFT:
      begin
        bi.cmd = (q.is_rx && !q.addr_ph) ? twm_pkg::TWM_CMD_RD :
          twm_pkg::TWM_CMD_WR;
        bi.wbit = q.sh[7];
        if (!q.wt)
        begin
          bi.req = 1'b1;
          n.wt = 1'b1;
        end
        else if (bi.done)
        begin
          n.wt = 1'b0;
          n.sh = {q.sh[6:0], bi.rbit};
          n.bitn = q.bitn - 3'h1;
          if (q.bitn != 3'h0)
            n.st = twm_pkg::TWM_ST_SHIFT;
          else if (q.is_rx && !q.addr_ph)
          begin
            n.rxd = {q.sh[6:0], bi.rbit};
            ev_set[twm_pkg::TWM_EV_RX] = 1'b1;
            n.st = twm_pkg::TWM_ST_RXHOLD;
          end
          else
            n.st = twm_pkg::TWM_ST_ACKIN;
        end
      end
      twm_pkg::TWM_ST_ACKIN:
      begin
        bi.cmd = twm_pkg::TWM_CMD_RD;
        if (!q.wt)
        begin
          bi.req = 1'b1;
          n.wt = 1'b1;
        end
        else if (bi.done)
        begin
          n.wt = 1'b0;
          n.addr_ph = 1'b0;
          if (bi.rbit)
          begin
            // A nack from the slave aborts with a stop
            ev_set[twm_pkg::TWM_EV_FAULT] = 1'b1;
            n.st = twm_pkg::TWM_ST_STOP;
          end
          else if (q.addr_ph && q.is_rx)
          begin
            ev_set[twm_pkg::TWM_EV_BB] = 1'b1;
            n.bitn = twm_pkg::TWM_BYTE_MSB;
            n.st = twm_pkg::TWM_ST_SHIFT;
          end
          else
          begin
            ev_set[twm_pkg::TWM_EV_TX] = !q.addr_ph;
            n.st = twm_pkg::TWM_ST_TXWAIT;
          end
        end
      end
      twm_pkg::TWM_ST_TXWAIT:
      begin
        // SCL stays low here until software supplies the next byte
        if (q.pend == twm_pkg::TWM_PEND_STOP)
        begin
          n.pend = twm_pkg::TWM_PEND_NONE;
          n.st = twm_pkg::TWM_ST_STOP;
        end
        else if (q.pend != twm_pkg::TWM_PEND_NONE)
          n = do_start(q);
        else if (q.txd_full)
        begin
          n.sh = q.txd;
          n.txd_full = 1'b0;
          n.bitn = twm_pkg::TWM_BYTE_MSB;
          n.st = twm_pkg::TWM_ST_SHIFT;
          ev_set[twm_pkg::TWM_EV_BB] = 1'b1;
        end
      end
      twm_pkg::TWM_ST_RXHOLD:
      begin
        // SCL low until receive data is read
        if (rxd_read)
        begin
          // a task already pending turns the ack into a nack
          n.nack = (q.pend != twm_pkg::TWM_PEND_NONE);
          n.st = twm_pkg::TWM_ST_ACKOUT;
        end
      end
      twm_pkg::TWM_ST_ACKOUT:
      begin
        bi.cmd = twm_pkg::TWM_CMD_WR;
        bi.wbit = q.nack;
        if (!q.wt)
        begin
          bi.req = 1'b1;
          n.wt = 1'b1;
        end
        else if (bi.done)
        begin
          n.wt = 1'b0;
          if (q.nack && q.pend == twm_pkg::TWM_PEND_STOP)
          begin
            // end of a read after the nack
            n.pend = twm_pkg::TWM_PEND_NONE;
            n.st = twm_pkg::TWM_ST_STOP;
          end
          else if (q.nack)
            n = do_start(q);
          else if (q.susp)
          begin
            // only with a pause requested earlier
            n.susp = 1'b0;
            ev_set[twm_pkg::TWM_EV_PAUSE] = 1'b1;
            n.st = twm_pkg::TWM_ST_SUSP;
          end
          else
          begin
            ev_set[twm_pkg::TWM_EV_BB] = 1'b1;
            n.bitn = twm_pkg::TWM_BYTE_MSB;
            n.st = twm_pkg::TWM_ST_SHIFT;
          end
        end
      end
      twm_pkg::TWM_ST_SUSP:
      begin
        if (q.pend == twm_pkg::TWM_PEND_STOP)
        begin
          n.pend = twm_pkg::TWM_PEND_NONE;
          n.st = twm_pkg::TWM_ST_STOP;
        end
        else if (wr && I_PADDR == twm_pkg::TWM_OFS_CONTINUE && w1)
        begin
          ev_set[twm_pkg::TWM_EV_BB] = 1'b1;
          n.bitn = twm_pkg::TWM_BYTE_MSB;
          n.st = twm_pkg::TWM_ST_SHIFT;
        end
      end
      twm_pkg::TWM_ST_STOP:
      begin
        bi.cmd = twm_pkg::TWM_CMD_STOP;
        if (!q.wt)
        begin
          bi.req = 1'b1;
          n.wt = 1'b1;
        end
        else if (bi.done)
        begin
          n.wt = 1'b0;
          n.susp = 1'b0;
          ev_set[twm_pkg::TWM_EV_HALT] = 1'b1;
          n.st = twm_pkg::TWM_ST_IDLE;
        end
      end
      default: n.st = twm_pkg::TWM_ST_IDLE;
    endcase

    // Task triggers come after the sequencer so none is lost
    if (wr && w1)
    begin
      unique case (I_PADDR)
        twm_pkg::TWM_OFS_BEGIN_RX: n.pend = twm_pkg::TWM_PEND_SRX;
        twm_pkg::TWM_OFS_BEGIN_TX: n.pend = twm_pkg::TWM_PEND_STX;
        // stop request held until a safe point
        twm_pkg::TWM_OFS_END: n.pend = twm_pkg::TWM_PEND_STOP;
        twm_pkg::TWM_OFS_PAUSE: n.susp = 1'b1;
        default: ;
      endcase
    end

    // Data and control writes
    if (wr && I_PADDR == twm_pkg::TWM_OFS_TXD)
    begin
      n.txd = I_PWDATA[7:0];
      n.txd_full = 1'b1;
    end
    if (wr && I_PADDR == twm_pkg::TWM_OFS_ADDR)
      n.addr = I_PWDATA[6:0];
    if (wr && I_PADDR == twm_pkg::TWM_OFS_IRQ_EN)
      n.irq_en = I_PWDATA[twm_pkg::TWM_NEV-1:0];

    // write 0 clears a flag; a new event wins over the clear
    for (int i = 0; i < twm_pkg::TWM_NEV; i++)
    begin
      if (wr && I_PADDR == twm_pkg::TWM_EV_OFS[i])
        n.ev[i] = I_PWDATA[0] | ev_set[i];
      else
        n.ev[i] = q.ev[i] | ev_set[i];
    end

    // Interrupt status: write 1 clears, set wins
    if (wr && I_PADDR == twm_pkg::TWM_OFS_IRQ_CLR)
      n.irq_st = (q.irq_st & ~I_PWDATA[twm_pkg::TWM_NEV-1:0]) | ev_set;
    else
      n.irq_st = q.irq_st | ev_set;
    n.irq = |(n.irq_st & n.irq_en);

    // Read data is fetched in the setup cycle; task registers read 0
    for (int i = 0; i < twm_pkg::TWM_NEV; i++)
      if (I_PADDR == twm_pkg::TWM_EV_OFS[i])
        rmux = {31'h0000_0000, q.ev[i]};
    unique case (I_PADDR)
      twm_pkg::TWM_OFS_RXD: rmux = {24'h00_0000, q.rxd};
      twm_pkg::TWM_OFS_TXD: rmux = {24'h00_0000, q.txd};
      twm_pkg::TWM_OFS_ADDR: rmux = {25'h000_0000, q.addr};
      twm_pkg::TWM_OFS_IRQ_STAT: rmux = {26'h000_0000, q.irq_st};
      twm_pkg::TWM_OFS_IRQ_EN: rmux = {26'h000_0000, q.irq_en};
      default: ;
    endcase
    if (I_PSEL && !I_PENABLE && !I_PWRITE)
      n.prdata = rmux;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // flags clear on reset
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      q <= '0;
      q.ev <= twm_pkg::TWM_EV_RST;
    end
    else
      q <= n;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Zero wait state: the access phase always completes at once
  assign O_PREADY = I_PSEL && I_PENABLE;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped(I_PADDR);
  assign O_PRDATA = q.prdata;
  assign O_IRQ = q.irq;
  // Open drain: only ever drive low
  assign O_SCL = 1'b0;
  assign O_SDA = 1'b0;

endmodule

//--- verification/twm_slave_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Behavioural slave on the two-wire bus
// ------------------------------------------------------------
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] RDATA = 8'ha5
) (
  // Resolved bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // High pulls SDA low
  output logic o_sda_oe
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] last_wr = 8'h00;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic adr = 1'b0;
  logic nack_seen = 1'b0;
  logic skip = 1'b0;
  initial o_sda_oe = 1'b0;

  // Start or stop: SDA moves while SCL is high
  always @(i_sda)
    if (i_scl === 1'b1)
    begin
      cnt = 4'h0;
      adr = !i_sda;
      act = 1'b0;
      o_sda_oe = 1'b0;
      // The SCL fall that closes a start is no bit slot
      skip = 1'b1;
    end

  // Sample on rising SCL; a high bit in the master's ack slot is a nack
  always @(posedge i_scl)
    if (cnt < 4'h8)
      sh = {sh[6:0], i_sda};
    else if (rd && act && !adr && i_sda)
      nack_seen = 1'b1;

  // Change SDA only while SCL is low, so no false start or stop
  always @(negedge i_scl)
    if (skip)
      skip = 1'b0;
    else
    begin
      cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8 && adr)
      begin
        act = (sh[7:1] == ADDR);
        rd = sh[0];
      end
      if (cnt == 4'h8 && act && !adr && !rd)
        last_wr = sh;
      if (cnt == 4'h0)
        adr = 1'b0;
      o_sda_oe = act && ((cnt == 4'h8 && (adr || !rd)) ||
        (rd && !adr && cnt < 4'h8 && !RDATA[3'h7 - cnt[2:0]]));
    end
endmodule

//--- verification/twm_top_sva.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checks for the two-wire master
// ------------------------------------------------------------
module twm_top_sva #(
  parameter int QTR_CYC = 250
) (
  // Clock, reset and APB
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Bus pins and interrupt
  input wire logic I_SCL,
  input wire logic O_SCL,
  input wire logic O_SCL_OE,
  input wire logic I_SDA,
  input wire logic O_SDA,
  input wire logic O_SDA_OE,
  input wire logic O_IRQ
);
  // Start must pull SDA within three quarter phases plus sync delay
  localparam int START_MAX = 3 * QTR_CYC + 16;
  logic acc;
  logic rda;
  assign acc = I_PSEL && I_PENABLE;
  assign rda = acc && !I_PWRITE;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);

  // Every mapped register answers cleanly, any other address errs
  property p_ready;
    acc |-> O_PREADY && (O_PSLVERR == !(I_PADDR inside {12'h000, 12'h008,
      12'h014, 12'h01c, 12'h020, 12'h104, 12'h108, 12'h11c, 12'h124,
      12'h138, 12'h148, 12'h518, 12'h51c, 12'h588, 12'h600, 12'h604,
      12'h608}));
  endproperty
  a_ready: assert property (p_ready) else $error("bad ready or error");
  property p_trig;
    rda && I_PADDR inside {12'h000, 12'h008, 12'h014, 12'h01c, 12'h020}
      |-> O_PRDATA == 32'h0;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger read");
  property p_flag;
    rda && I_PADDR inside {12'h104, 12'h108, 12'h11c, 12'h124, 12'h138,
      12'h148} |-> O_PRDATA[31:1] == 31'h0;
  endproperty
  a_flag: assert property (p_flag) else $error("flag width");
  property p_rst;
    $rose(I_RSTN) |-> !O_IRQ && !O_SCL_OE && !O_SDA_OE;
  endproperty
  a_rst: assert property (p_rst) else $error("not quiet");
  property p_start;
    acc && I_PWRITE && I_PWDATA[0] && I_PADDR inside {12'h000, 12'h008}
      && !O_SCL_OE && !O_SDA_OE && I_SCL && I_SDA
      |-> ##[1:START_MAX] O_SDA_OE;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_irqoff;
    acc && I_PWRITE && I_PADDR == 12'h608 && I_PWDATA == 32'h0
      |-> ##[1:2] !O_IRQ;
  endproperty
  a_irqoff: assert property (p_irqoff) else $error("irq not masked");
  property p_hold;
    rda |=> $stable(O_PRDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_drain;
    !O_SCL && !O_SDA;
  endproperty
  a_drain: assert property (p_drain) else $error("pin driven high");
  c_start: cover property (p_start);
  c_err: cover property (acc && O_PSLVERR);
  c_irq: cover property ($rose(O_IRQ));
endmodule

bind twm_top twm_top_sva #(.QTR_CYC(QTR_CYC)) u_twm_top_sva (
  .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_SCL(I_SCL), .O_SCL(O_SCL), .O_SCL_OE(O_SCL_OE), .I_SDA(I_SDA),
  .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .O_IRQ(O_IRQ));

//--- verification/testbench.sv
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      error_cnt++; \
      $display("Error %0t: got %h expected %h", $time, (a), (e)); \
    end \
  end
// ------------------------------------------------------------
// Bench for the two-wire master
// ------------------------------------------------------------
module testbench;
  localparam int QTR = 2;
  localparam logic [6:0] SADR = 7'h2a;
  localparam logic [7:0] SDAT = 8'ha5;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl_oe;
  logic sda_oe;
  logic slv_oe;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  int error_cnt = 0;
  int check_count = 0;
  wire scl;
  wire sda;
  // Open-drain wires with pull-ups
  assign scl = !scl_oe;
  assign sda = !(sda_oe || slv_oe);

  twm_top #(.QTR_CYC(QTR)) u_twm_top (
    .I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SCL(scl), .O_SCL(), .O_SCL_OE(scl_oe), .I_SDA(sda), .O_SDA(),
    .O_SDA_OE(sda_oe), .O_IRQ(irq));
  twm_slave_model #(.ADDR(SADR), .RDATA(SDAT)) u_twm_slave_model (
    .i_scl(scl), .i_sda(sda), .o_sda_oe(slv_oe));

  // Free-running 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Poll one event flag; a limit of 3000 reads bounds a hang
  task automatic wait_flag(input int i);
    int n;
    begin
      n = 0;
      rdat = 32'h0;
      while (rdat[0] !== 1'b1 && n < 3000)
      begin
        apb(1'b0, twm_pkg::TWM_EV_OFS[i], 32'h0);
        n++;
      end
      `CHK(rdat, 32'h1)
    end
  endtask

  task automatic test_done;
    begin
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < twm_pkg::TWM_NEV; i++)
    begin
      apb(1'b0, twm_pkg::TWM_EV_OFS[i], 32'h0);
      `CHK(rdat, 32'h0)
    end
    apb(1'b0, twm_pkg::TWM_OFS_BEGIN_RX, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b0, 12'hffc, 32'h0);
    `CHK(rerr, 1'b1)
    // Write one byte, then stop
    apb(1'b1, twm_pkg::TWM_OFS_ADDR, {25'h0, SADR});
    apb(1'b1, twm_pkg::TWM_OFS_IRQ_EN, 32'h1);
    apb(1'b1, twm_pkg::TWM_OFS_TXD, 32'h5c);
    apb(1'b1, twm_pkg::TWM_OFS_BEGIN_TX, 32'h1);
    wait_flag(twm_pkg::TWM_EV_TX);
    `CHK(u_twm_slave_model.last_wr, 8'h5c)
    apb(1'b0, twm_pkg::TWM_EV_OFS[twm_pkg::TWM_EV_BB], 32'h0);
    `CHK(rdat, 32'h1)
    apb(1'b1, twm_pkg::TWM_OFS_END, 32'h1);
    wait_flag(twm_pkg::TWM_EV_HALT);
    `CHK(irq, 1'b1)
    // Interrupt masked, unmasked, then cleared
    apb(1'b1, twm_pkg::TWM_OFS_IRQ_EN, 32'h0);
    apb(1'b0, twm_pkg::TWM_OFS_IRQ_STAT, 32'h0);
    `CHK(irq, 1'b0)
    apb(1'b1, twm_pkg::TWM_OFS_IRQ_EN, 32'h1);
    apb(1'b1, twm_pkg::TWM_OFS_IRQ_CLR, 32'h3f);
    apb(1'b0, twm_pkg::TWM_OFS_IRQ_STAT, 32'h0);
    `CHK(rdat, 32'h0)
    `CHK(irq, 1'b0)
    for (int i = 0; i < twm_pkg::TWM_NEV; i++)
      apb(1'b1, twm_pkg::TWM_EV_OFS[i], 32'h0);
    apb(1'b0, twm_pkg::TWM_EV_OFS[twm_pkg::TWM_EV_HALT], 32'h0);
    `CHK(rdat, 32'h0)
    // Read with a pause after the first byte
    apb(1'b1, twm_pkg::TWM_OFS_PAUSE, 32'h1);
    apb(1'b1, twm_pkg::TWM_OFS_BEGIN_RX, 32'h1);
    wait_flag(twm_pkg::TWM_EV_RX);
    repeat (40) @(posedge clk);
    `CHK(scl_oe, 1'b1)
    apb(1'b0, twm_pkg::TWM_EV_OFS[twm_pkg::TWM_EV_PAUSE], 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b0, twm_pkg::TWM_OFS_RXD, 32'h0);
    `CHK(rdat[7:0], SDAT)
    wait_flag(twm_pkg::TWM_EV_PAUSE);
    `CHK(scl_oe, 1'b1)
    apb(1'b1, twm_pkg::TWM_EV_OFS[twm_pkg::TWM_EV_RX], 32'h0);
    apb(1'b1, twm_pkg::TWM_EV_OFS[twm_pkg::TWM_EV_PAUSE], 32'h0);
    apb(1'b1, twm_pkg::TWM_OFS_CONTINUE, 32'h1);
    wait_flag(twm_pkg::TWM_EV_RX);
    // Stop before reading the last byte gives a nack
    apb(1'b1, twm_pkg::TWM_OFS_END, 32'h1);
    apb(1'b0, twm_pkg::TWM_OFS_RXD, 32'h0);
    `CHK(rdat[7:0], SDAT)
    wait_flag(twm_pkg::TWM_EV_HALT);
    `CHK(u_twm_slave_model.nack_seen, 1'b1)
    apb(1'b0, twm_pkg::TWM_EV_OFS[twm_pkg::TWM_EV_PAUSE], 32'h0);
    `CHK(rdat, 32'h0)
    `CHK({scl, sda}, 2'h3)
    // Unknown address: nobody acks, so a fault and a stop follow
    apb(1'b1, twm_pkg::TWM_EV_OFS[twm_pkg::TWM_EV_HALT], 32'h0);
    apb(1'b1, twm_pkg::TWM_OFS_ADDR, 32'h11);
    apb(1'b1, twm_pkg::TWM_OFS_BEGIN_TX, 32'h1);
    wait_flag(twm_pkg::TWM_EV_FAULT);
    wait_flag(twm_pkg::TWM_EV_HALT);
    test_done;
  end

  // Watchdog well beyond the expected thousand or so cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    test_done;
  end
endmodule
